// File: xpt_pkg.sv
// Shared constants and stream word type for the XGMII timestamp tap wrapper.
package xpt_pkg;
   typedef struct packed {
      logic [63:0] data;
      logic [7:0]  keep;
      logic        last;
   } xpt_word_s;
   typedef enum logic [1:0] {
      XPT_TX_IDLE = 2'b00,
      XPT_TX_DATA = 2'b01,
      XPT_TX_TERM = 2'b10,
      XPT_TX_GAP  = 2'b11
   } xpt_tx_state_e;
   localparam logic [7:0]  XG_START    = 8'hfb;
   localparam logic [7:0]  XG_TERM     = 8'hfd;
   localparam logic [7:0]  XG_IDLE     = 8'h07;
   localparam logic [63:0] XG_PREAMBLE = 64'hd555_5555_5555_55fb;
   localparam logic [63:0] XG_IDLES    = 64'h0707_0707_0707_0707;
   localparam logic [7:0]  XG_CTRL_ALL = 8'hff;
   localparam logic [7:0]  XG_CTRL_SOF = 8'h01;
   localparam logic [15:0] PTP_ETYPE   = 16'h88f7;
   localparam int          FIFO_AW     = 8;
   localparam int          ROOM_MARGIN = 4;
   localparam int          IFG_BYTES   = 12;
   localparam logic [1:0]  IFG_WORDS   = 2'((IFG_BYTES + 7) / 8);
   localparam logic [1:0]  IDX_FIRST   = 2'h0;
   localparam logic [1:0]  IDX_ETYPE   = 2'h1;
   localparam logic [1:0]  IDX_LATER   = 2'h2;
endpackage

// File: xpt_wrapper.sv
// XGMII timestamp tap wrapper: adapters, arbiters, PTP filter, frame FIFOs and width converters.
`timescale 1ns/1ns

module xpt_fifo (
   input  wire logic               wclk_in,
   input  wire logic               rclk_in,
   input  wire logic               rst_in,
   input  wire xpt_pkg::xpt_word_s w_word_in,
   input  wire logic               w_valid_in,
   input  wire logic               w_drop_in,
   output logic                    w_room_out,
   output xpt_pkg::xpt_word_s      r_word_out,
   output logic                    r_avail_out,
   input  wire logic               r_take_in
);
   localparam int AW = xpt_pkg::FIFO_AW;
   localparam int ROOM_MARGIN = xpt_pkg::ROOM_MARGIN;
   localparam logic [AW:0] DEPTH = (AW + 1)'(1 << AW);
   xpt_pkg::xpt_word_s mem [2**AW];
   logic [AW:0] wcur_reg, wcom_reg, wgray_reg, rptr_reg, rgray_reg;
   logic [AW:0] wg1_reg, wg2_reg, rg1_reg, rg2_reg;
   logic        bad_reg;
   function automatic logic [AW:0] g2b(input logic [AW:0] g);
      logic [AW:0] b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) b[i] = b[i + 1] ^ g[i];
      return b;
   endfunction
   wire logic [AW:0] used     = wcur_reg - g2b(rg2_reg);
   wire logic        full     = used == DEPTH;
   // A frame goes bad on its drop input or on the first word that finds no room.
   wire logic        bad_next = bad_reg | (w_valid_in & (w_drop_in | full));
   wire logic        wr_en    = w_valid_in & !bad_next;
   wire logic        fin      = w_valid_in & w_word_in.last;
   wire logic [AW:0] wcur_inc = wcur_reg + 1'b1;
   wire logic [AW:0] rptr_inc = rptr_reg + 1'b1;
   wire logic        rd_en    = r_take_in & r_avail_out;
   // Only committed frames are published, so the reader never sees a partial frame.
   assign r_avail_out = rgray_reg != wg2_reg;
   assign r_word_out  = mem[rptr_reg[AW-1:0]];
   always_ff @(posedge wclk_in) begin
      if (wr_en) mem[wcur_reg[AW-1:0]] <= w_word_in;
   end
   always_ff @(posedge wclk_in or posedge rst_in) begin
      if (rst_in) begin
         wcur_reg   <= '0;
         wcom_reg   <= '0;
         wgray_reg  <= '0;
         bad_reg    <= 1'b0;
         rg1_reg    <= '0;
         rg2_reg    <= '0;
         w_room_out <= 1'b0;
      end else begin
         wcur_reg   <= fin ? (bad_next ? wcom_reg : wcur_inc) : (wr_en ? wcur_inc : wcur_reg);
         wcom_reg   <= (fin & !bad_next) ? wcur_inc : wcom_reg;
         bad_reg    <= fin ? 1'b0 : bad_next;
         wgray_reg  <= wcom_reg ^ (wcom_reg >> 1);
         rg1_reg    <= rgray_reg;
         rg2_reg    <= rg1_reg;
         w_room_out <= used < DEPTH - ROOM_MARGIN;
      end
   end
   always_ff @(posedge rclk_in or posedge rst_in) begin
      if (rst_in) begin
         rptr_reg  <= '0;
         rgray_reg <= '0;
         wg1_reg   <= '0;
         wg2_reg   <= '0;
      end else begin
         rptr_reg  <= rd_en ? rptr_inc : rptr_reg;
         rgray_reg <= rd_en ? (rptr_inc ^ (rptr_inc >> 1)) : rgray_reg;
         wg1_reg   <= wgray_reg;
         wg2_reg   <= wg1_reg;
      end
   end
   a_frame_whole: assert property (@(posedge wclk_in) disable iff (rst_in)
      fin && bad_next |=> wcur_reg == wcom_reg && wcom_reg == $past(wcom_reg)) else $error("Bad frame was kept.");
endmodule

module xpt_rx_adapt (
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic [63:0]   xd_in,
   input  wire logic [7:0]    xc_in,
   output xpt_pkg::xpt_word_s word_out,
   output logic               valid_out
);
   logic [63:0]        pd_reg;
   logic [7:0]         pc_reg;
   logic               sh_reg, inf_reg, pv_reg;
   xpt_pkg::xpt_word_s pend_reg;
   logic [7:0]         kp;
   // Starts in lane four are realigned by half a word so decoding sees lane zero only.
   wire logic s0 = pc_reg[0] & (pd_reg[7:0] == xpt_pkg::XG_START);
   wire logic s4 = pc_reg[4] & (pd_reg[39:32] == xpt_pkg::XG_START);
   wire logic sh = s0 ? 1'b0 : (s4 ? 1'b1 : sh_reg);
   wire logic [63:0] ad = sh ? {xd_in[31:0], pd_reg[63:32]} : pd_reg;
   wire logic [7:0]  ac = sh ? {xc_in[3:0], pc_reg[7:4]} : pc_reg;
   wire logic st   = !inf_reg & ac[0] & (ad[7:0] == xpt_pkg::XG_START);
   wire logic term = inf_reg & (|ac);
   for (genvar i = 0; i < 8; i++) begin : g_keep
      assign kp[i] = ~|ac[i:0];
   end
   wire logic take = inf_reg & (|kp);
   // Output lags one word so a terminate in lane zero can still mark the previous word last.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pd_reg    <= xpt_pkg::XG_IDLES;
         pc_reg    <= xpt_pkg::XG_CTRL_ALL;
         sh_reg    <= 1'b0;
         inf_reg   <= 1'b0;
         pv_reg    <= 1'b0;
         pend_reg  <= '0;
         word_out  <= '0;
         valid_out <= 1'b0;
      end else begin
         pd_reg    <= xd_in;
         pc_reg    <= xc_in;
         sh_reg    <= sh;
         inf_reg   <= inf_reg ? !term : st;
         pv_reg    <= take;
         pend_reg  <= take ? '{data: ad, keep: kp, last: term} : pend_reg;
         valid_out <= pv_reg;
         word_out  <= '{data: pend_reg.data, keep: pend_reg.keep, last: pend_reg.last | (inf_reg & ~|kp)};
      end
   end
   a_rx_strip: assert property (@(posedge clk_in) disable iff (rst_in)
      st |=> inf_reg && !pv_reg ##1 !valid_out) else $error("Start word leaked into stream.");
endmodule

module xpt_tx_adapt (
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire xpt_pkg::xpt_word_s word_in,
   input  wire logic               valid_in,
   output logic                    ready_out,
   output logic [63:0]             xd_out,
   output logic [7:0]              xc_out,
   output logic                    sof_out
);
   xpt_pkg::xpt_tx_state_e st_reg;
   logic [1:0]  gap_reg;
   logic [63:0] ld;
   logic [7:0]  lc;
   wire logic [7:0] kprev = {word_in.keep[6:0], 1'b1};
   for (genvar i = 0; i < 8; i++) begin : g_lane
      assign lc[i] = !word_in.keep[i];
      assign ld[i*8 +: 8] = word_in.keep[i] ? word_in.data[i*8 +: 8] : (kprev[i] ? xpt_pkg::XG_TERM : xpt_pkg::XG_IDLE);
   end
   assign ready_out = st_reg == xpt_pkg::XPT_TX_DATA;
   wire logic beat = ready_out & valid_in;
   wire logic full_end = beat & word_in.last & (&word_in.keep);
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg  <= xpt_pkg::XPT_TX_IDLE;
         gap_reg <= 2'h0;
         xd_out  <= xpt_pkg::XG_IDLES;
         xc_out  <= xpt_pkg::XG_CTRL_ALL;
         sof_out <= 1'b0;
      end else begin
         sof_out <= 1'b0;
         xd_out  <= xpt_pkg::XG_IDLES;
         xc_out  <= xpt_pkg::XG_CTRL_ALL;
         gap_reg <= (st_reg == xpt_pkg::XPT_TX_GAP) ? gap_reg - 2'h1 : xpt_pkg::IFG_WORDS;
         unique case (st_reg)
            xpt_pkg::XPT_TX_IDLE: if (valid_in) begin
               xd_out  <= xpt_pkg::XG_PREAMBLE;
               xc_out  <= xpt_pkg::XG_CTRL_SOF;
               sof_out <= 1'b1;
               st_reg  <= xpt_pkg::XPT_TX_DATA;
            end
            xpt_pkg::XPT_TX_DATA: if (beat) begin
               xd_out <= ld;
               xc_out <= lc;
               if (word_in.last) st_reg <= full_end ? xpt_pkg::XPT_TX_TERM : xpt_pkg::XPT_TX_GAP;
            end
            xpt_pkg::XPT_TX_TERM: begin
               xd_out <= {{7{xpt_pkg::XG_IDLE}}, xpt_pkg::XG_TERM};
               st_reg <= xpt_pkg::XPT_TX_GAP;
            end
            xpt_pkg::XPT_TX_GAP: if (gap_reg == 2'h1) st_reg <= xpt_pkg::XPT_TX_IDLE;
         endcase
      end
   end
   a_tx_gap_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      beat && word_in.last |=> ##1 (xc_out == 8'hff) [*2]) else $error("Inter-frame gap too short.");
   a_tx_preamble: assert property (@(posedge clk_in) disable iff (rst_in)
      st_reg == xpt_pkg::XPT_TX_IDLE && valid_in |=> xd_out == 64'hd555_5555_5555_55fb && xc_out == 8'h01 && ready_out)
      else $error("Frame did not open with preamble in lane zero.");
   a_tx_midword: assert property (@(posedge clk_in) disable iff (rst_in)
      beat && !word_in.last |=> xc_out == 8'h00 && xd_out == $past(word_in.data)) else $error("Data word miscoded.");
endmodule

module xpt_arb (
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire xpt_pkg::xpt_word_s w0_in,
   input  wire logic               v0_in,
   input  wire xpt_pkg::xpt_word_s w1_in,
   input  wire logic               v1_in,
   output xpt_pkg::xpt_word_s      word_out,
   output logic                    valid_out,
   input  wire logic               ready_in,
   output logic [1:0]              take_out,
   output logic                    sel_out
);
   logic busy_reg, own_reg, lst_reg;
   // With both requesting, the side that did not win last time gets the grant.
   wire logic       pick = (v0_in & v1_in) ? !lst_reg : v1_in;
   wire logic [1:0] gnt  = busy_reg ? (own_reg ? 2'b10 : 2'b01) : 2'b00;
   assign sel_out   = own_reg;
   assign word_out  = own_reg ? w1_in : w0_in;
   assign valid_out = own_reg ? (v1_in & gnt[1]) : (v0_in & gnt[0]);
   assign take_out  = gnt & {2{ready_in}};
   wire logic done = valid_out & ready_in & word_out.last;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_reg <= 1'b0;
         own_reg  <= 1'b0;
         lst_reg  <= 1'b0;
      end else if (!busy_reg) begin
         busy_reg <= v0_in | v1_in;
         own_reg  <= (v0_in | v1_in) ? pick : own_reg;
         lst_reg  <= (v0_in | v1_in) ? pick : lst_reg;
      end else begin
         busy_reg <= !done;
      end
   end
   a_arb_turn: assert property (@(posedge clk_in) disable iff (rst_in)
      !busy_reg && v0_in && v1_in |=> busy_reg && own_reg != $past(lst_reg)) else $error("Arbiter did not alternate.");
endmodule

module xpt_wrapper (
   input  wire logic        clk_in,
   input  wire logic        xgmii_clk_in,
   input  wire logic        rst_in,
   input  wire logic [63:0] mac_txd_in,
   input  wire logic [7:0]  mac_txc_in,
   output logic      [63:0] pcs_txd_out,
   output logic      [7:0]  pcs_txc_out,
   input  wire logic [63:0] pcs_rxd_in,
   input  wire logic [7:0]  pcs_rxc_in,
   output logic      [63:0] mac_rxd_out,
   output logic      [7:0]  mac_rxc_out,
   input  wire logic [31:0] tu_tx_data_in,
   input  wire logic [3:0]  tu_tx_keep_in,
   input  wire logic        tu_tx_last_in,
   input  wire logic        tu_tx_valid_in,
   output logic             tu_tx_ready_out,
   output logic      [31:0] tu_rx_data_out,
   output logic      [3:0]  tu_rx_keep_out,
   output logic             tu_rx_last_out,
   output logic             tu_rx_valid_out,
   input  wire logic        tu_rx_ready_in,
   output logic             tu_tx_event_out,
   output logic             tu_rx_event_out
);
   xpt_pkg::xpt_word_s mt_w, ft_w, ct_w, at_w, pr_w, fr_w, cr_w, ar_w, pk_w_reg;
   logic       mt_v, ft_v, ct_v, at_v, at_r, at_sel, at_sof, pr_v, fr_v, cr_v, ar_v, ar_r, pk_v_reg;
   logic [1:0] tk_tx, tk_rx, idx_reg, tg_reg, es1_reg, es2_reg, es3_reg;
   logic       ptp_reg, lo_v_reg, hi_reg;
   logic [31:0] lo_d_reg;
   logic [3:0]  lo_k_reg;
   wire logic   cr_last = hi_reg | ~|cr_w.keep[7:4];
   wire logic   ld      = !tu_rx_valid_out | tu_rx_ready_in;
   wire logic   cr_take = ld & cr_v & cr_last;

   xpt_rx_adapt u_mac_dec (.clk_in(xgmii_clk_in), .rst_in(rst_in), .xd_in(mac_txd_in), .xc_in(mac_txc_in),
      .word_out(mt_w), .valid_out(mt_v));
   xpt_fifo u_fwd_tx (.wclk_in(xgmii_clk_in), .rclk_in(xgmii_clk_in), .rst_in(rst_in), .w_word_in(mt_w),
      .w_valid_in(mt_v), .w_drop_in(1'b0), .w_room_out(), .r_word_out(ft_w), .r_avail_out(ft_v), .r_take_in(tk_tx[0]));
   xpt_fifo u_cnv_tx (.wclk_in(clk_in), .rclk_in(xgmii_clk_in), .rst_in(rst_in), .w_word_in(pk_w_reg),
      .w_valid_in(pk_v_reg), .w_drop_in(1'b0), .w_room_out(tu_tx_ready_out), .r_word_out(ct_w), .r_avail_out(ct_v),
      .r_take_in(tk_tx[1]));
   xpt_arb u_arb_tx (.clk_in(xgmii_clk_in), .rst_in(rst_in), .w0_in(ft_w), .v0_in(ft_v), .w1_in(ct_w), .v1_in(ct_v),
      .word_out(at_w), .valid_out(at_v), .ready_in(at_r), .take_out(tk_tx), .sel_out(at_sel));
   xpt_tx_adapt u_pcs_enc (.clk_in(xgmii_clk_in), .rst_in(rst_in), .word_in(at_w), .valid_in(at_v), .ready_out(at_r),
      .xd_out(pcs_txd_out), .xc_out(pcs_txc_out), .sof_out(at_sof));

   xpt_rx_adapt u_pcs_dec (.clk_in(xgmii_clk_in), .rst_in(rst_in), .xd_in(pcs_rxd_in), .xc_in(pcs_rxc_in),
      .word_out(pr_w), .valid_out(pr_v));
   // The ethertype sits in lanes four and five of the second word, well before any last word.
   wire logic et_hit   = {pr_w.data[39:32], pr_w.data[47:40]} == xpt_pkg::PTP_ETYPE;
   wire logic is_ptp   = (idx_reg == xpt_pkg::IDX_ETYPE) ? et_hit : ptp_reg;
   wire logic known    = pr_v & (idx_reg != xpt_pkg::IDX_FIRST);
   wire logic drop_fwd = known & is_ptp;
   wire logic drop_cnv = known & !is_ptp;
   xpt_fifo u_fwd_rx (.wclk_in(xgmii_clk_in), .rclk_in(xgmii_clk_in), .rst_in(rst_in), .w_word_in(pr_w),
      .w_valid_in(pr_v), .w_drop_in(drop_fwd), .w_room_out(), .r_word_out(fr_w), .r_avail_out(fr_v),
      .r_take_in(tk_rx[0]));
   xpt_fifo u_cnv_rx (.wclk_in(xgmii_clk_in), .rclk_in(clk_in), .rst_in(rst_in), .w_word_in(pr_w),
      .w_valid_in(pr_v), .w_drop_in(drop_cnv), .w_room_out(), .r_word_out(cr_w), .r_avail_out(cr_v),
      .r_take_in(cr_take));
   xpt_arb u_arb_rx (.clk_in(xgmii_clk_in), .rst_in(rst_in), .w0_in(fr_w), .v0_in(fr_v), .w1_in('0), .v1_in(1'b0),
      .word_out(ar_w), .valid_out(ar_v), .ready_in(ar_r), .take_out(tk_rx), .sel_out());
   xpt_tx_adapt u_mac_enc (.clk_in(xgmii_clk_in), .rst_in(rst_in), .word_in(ar_w), .valid_in(ar_v), .ready_out(ar_r),
      .xd_out(mac_rxd_out), .xc_out(mac_rxc_out), .sof_out());

   always_ff @(posedge xgmii_clk_in or posedge rst_in) begin
      if (rst_in) begin
         idx_reg <= xpt_pkg::IDX_FIRST;
         ptp_reg <= 1'b0;
         tg_reg  <= 2'h0;
      end else begin
         if (pr_v) idx_reg <= pr_w.last ? xpt_pkg::IDX_FIRST : (known ? xpt_pkg::IDX_LATER : xpt_pkg::IDX_ETYPE);
         ptp_reg <= is_ptp;
         tg_reg  <= tg_reg ^ {pr_v & !known, at_sof & at_sel};
      end
   end

   // Event toggles cross by a plain two-stage synchroniser; this costs up to one system clock of jitter.
   wire logic       tb      = tu_tx_valid_in & tu_tx_ready_out;
   wire logic [3:0] hk      = lo_v_reg ? tu_tx_keep_in : 4'h0;
   wire xpt_pkg::xpt_word_s pk_next = '{data: lo_v_reg ? {tu_tx_data_in, lo_d_reg} : {32'h0, tu_tx_data_in},
      keep: {hk, lo_v_reg ? lo_k_reg : tu_tx_keep_in}, last: tu_tx_last_in};
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         es1_reg <= 2'h0;
         es2_reg <= 2'h0;
         es3_reg <= 2'h0;
         {tu_rx_event_out, tu_tx_event_out} <= 2'h0;
         lo_v_reg <= 1'b0;
         lo_d_reg <= 32'h0;
         lo_k_reg <= 4'h0;
         pk_w_reg <= '0;
         pk_v_reg <= 1'b0;
         hi_reg   <= 1'b0;
         tu_rx_valid_out <= 1'b0;
         tu_rx_data_out  <= 32'h0;
         tu_rx_keep_out  <= 4'h0;
         tu_rx_last_out  <= 1'b0;
      end else begin
         es1_reg <= tg_reg;
         es2_reg <= es1_reg;
         es3_reg <= es2_reg;
         {tu_rx_event_out, tu_tx_event_out} <= es2_reg ^ es3_reg;
         pk_v_reg <= tb & (lo_v_reg | tu_tx_last_in);
         pk_w_reg <= pk_next;
         if (tb) begin
            lo_v_reg <= !lo_v_reg & !tu_tx_last_in;
            lo_d_reg <= tu_tx_data_in;
            lo_k_reg <= tu_tx_keep_in;
         end
         if (ld) begin
            tu_rx_valid_out <= cr_v;
            tu_rx_data_out  <= hi_reg ? cr_w.data[63:32] : cr_w.data[31:0];
            tu_rx_keep_out  <= hi_reg ? cr_w.keep[7:4] : cr_w.keep[3:0];
            tu_rx_last_out  <= cr_w.last & cr_last;
            if (cr_v) hi_reg <= !cr_last;
         end
      end
   end

   a_drop_ptp: assert property (@(posedge xgmii_clk_in) disable iff (rst_in)
      pr_v && idx_reg == xpt_pkg::IDX_ETYPE && et_hit |-> drop_fwd && !drop_cnv)
      else $error("PTP frame not steered away from forwarding.");
   a_drop_later: assert property (@(posedge xgmii_clk_in) disable iff (rst_in)
      pr_v && idx_reg == xpt_pkg::IDX_LATER |-> drop_fwd == ptp_reg && drop_cnv == !ptp_reg)
      else $error("Drop decision changed within a frame.");
   a_rx_event: assert property (@(posedge xgmii_clk_in) disable iff (rst_in)
      pr_v && idx_reg == 2'h0 |=> tg_reg[1] != $past(tg_reg[1])) else $error("Receive frame start not signalled.");
   a_tx_event: assert property (@(posedge xgmii_clk_in) disable iff (rst_in)
      at_sof && at_sel |=> tg_reg[0] != $past(tg_reg[0])) else $error("Transmit frame start not signalled.");
   a_rx_narrow: assert property (@(posedge clk_in) disable iff (rst_in)
      tu_rx_valid_out && !tu_rx_ready_in |=> tu_rx_valid_out && $stable(tu_rx_data_out)) else $error("Output not held.");
endmodule

// File: xpt_xg_model.sv
// Behavioural XGMII frame source and frame sink standing in for the MAC and the PCS.
`timescale 1ns/1ns
module xpt_xg_src (
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic [8:0]  words_in,
   input  wire logic [15:0] etype_in,
   input  wire logic        lane4_in,
   output logic      [63:0] xd_out,
   output logic      [7:0]  xc_out
);
   logic [8:0] q[$];
   logic [8:0] e;
   // Frames are built as a byte queue so a lane-four start packs exactly like a lane-zero one.
   initial begin
      xd_out = xpt_pkg::XG_IDLES;
      xc_out = xpt_pkg::XG_CTRL_ALL;
      forever begin
         @(posedge clk_in iff go_in);
         if (lane4_in)
            repeat (4) q.push_back(9'h107);
         q.push_back(9'h1fb);
         repeat (6) q.push_back(9'h055);
         q.push_back(9'h0d5);
         for (int k = 0; k < 8 * words_in; k++)
            q.push_back({1'b0, k == 12 ? etype_in[15:8] : k == 13 ? etype_in[7:0] : 8'(k)});
         q.push_back(9'h1fd);
         while (q.size() % 8 != 0)
            q.push_back(9'h107);
         while (q.size() > 0) begin
            #1;
            for (int l = 0; l < 8; l++) begin
               e = q.pop_front();
               xd_out[l*8 +: 8] = e[7:0];
               xc_out[l] = e[8];
            end
            @(posedge clk_in);
         end
         #1;
         xd_out = xpt_pkg::XG_IDLES;
         xc_out = xpt_pkg::XG_CTRL_ALL;
      end
   end
endmodule

module xpt_xg_sink (
   input  wire logic        clk_in,
   input  wire logic [63:0] xd_in,
   input  wire logic [7:0]  xc_in,
   output logic      [15:0] ends_out,
   output logic      [15:0] bad_out
);
   logic [63:0] q[$];
   int          idle_run = 2;
   initial begin
      ends_out = 16'h0000;
      bad_out = 16'h0000;
   end
   always @(posedge clk_in) begin
      if (xc_in == 8'h00)
         q.push_back(xd_in);
      else if (xc_in == xpt_pkg::XG_CTRL_SOF && (xd_in != xpt_pkg::XG_PREAMBLE || idle_run < 2))
         bad_out++;
      else if (xc_in != xpt_pkg::XG_CTRL_SOF && xd_in != xpt_pkg::XG_IDLES)
         ends_out++;
      idle_run = (xd_in == xpt_pkg::XG_IDLES && xc_in == 8'hff) ? idle_run + 1 : 0;
   end
endmodule

// File: xpt_wrapper_test.sv
// Self-checking testbench for the XGMII timestamp tap wrapper.
`timescale 1ns/1ns
module xpt_wrapper_test;
   logic        clk_in = 1'b0, xgmii_clk_in = 1'b0, rst_in = 1'b1, m_go = 1'b0, p_go = 1'b0, lane4 = 1'b0;
   logic [8:0]  words = 9'h004;
   logic [15:0] etype = 16'h88f7, p_ends, p_bad, m_ends, m_bad;
   logic [63:0] mac_txd_in, pcs_txd_out, pcs_rxd_in, mac_rxd_out;
   logic [7:0]  mac_txc_in, pcs_txc_out, pcs_rxc_in, mac_rxc_out;
   logic [31:0] tu_tx_data_in = 32'h0, tu_rx_data_out, tu_q[$];
   logic [3:0]  tu_tx_keep_in = 4'hf, tu_rx_keep_out, lk;
   logic        tu_tx_last_in = 1'b0, tu_tx_valid_in = 1'b0, tu_rx_ready_in = 1'b0;
   logic        tu_tx_ready_out, tu_rx_last_out, tu_rx_valid_out, tu_tx_event_out, tu_rx_event_out;
   int          errors = 0, check_count = 0, lasts = 0, tx_evs = 0, rx_evs = 0, n0, e0;
   initial forever #4 clk_in = ~clk_in;
   initial forever begin
      #7 xgmii_clk_in = ~xgmii_clk_in;
      #8 xgmii_clk_in = ~xgmii_clk_in;
   end
   xpt_wrapper dut (.clk_in, .xgmii_clk_in, .rst_in, .mac_txd_in, .mac_txc_in, .pcs_txd_out, .pcs_txc_out,
      .pcs_rxd_in, .pcs_rxc_in, .mac_rxd_out, .mac_rxc_out, .tu_tx_data_in, .tu_tx_keep_in, .tu_tx_last_in,
      .tu_tx_valid_in, .tu_tx_ready_out, .tu_rx_data_out, .tu_rx_keep_out, .tu_rx_last_out, .tu_rx_valid_out,
      .tu_rx_ready_in, .tu_tx_event_out, .tu_rx_event_out);
   xpt_xg_src u_msrc (.clk_in(xgmii_clk_in), .go_in(m_go), .words_in(words), .etype_in(etype), .lane4_in(lane4),
      .xd_out(mac_txd_in), .xc_out(mac_txc_in));
   xpt_xg_src u_psrc (.clk_in(xgmii_clk_in), .go_in(p_go), .words_in(words), .etype_in(etype), .lane4_in(lane4),
      .xd_out(pcs_rxd_in), .xc_out(pcs_rxc_in));
   xpt_xg_sink u_pcs (.clk_in(xgmii_clk_in), .xd_in(pcs_txd_out), .xc_in(pcs_txc_out), .ends_out(p_ends),
      .bad_out(p_bad));
   xpt_xg_sink u_mac (.clk_in(xgmii_clk_in), .xd_in(mac_rxd_out), .xc_in(mac_rxc_out), .ends_out(m_ends),
      .bad_out(m_bad));
   // Stalling every other cycle makes the receive stream hold its words across refusals.
   always @(posedge clk_in) begin
      tu_rx_ready_in <= #1 ~tu_rx_ready_in;
      if (tu_rx_valid_out === 1'b1 && tu_rx_ready_in) begin
         tu_q.push_back(tu_rx_data_out);
         lk = tu_rx_keep_out;
      end
      if (tu_rx_valid_out === 1'b1 && tu_rx_ready_in && tu_rx_last_out === 1'b1)
         lasts++;
      if (tu_tx_event_out === 1'b1)
         tx_evs++;
      if (tu_rx_event_out === 1'b1)
         rx_evs++;
   end
   task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   function logic [63:0] ew(input int w);
      for (int l = 0; l < 8; l++)
         ew[l*8 +: 8] = (w*8 + l == 12) ? etype[15:8] : (w*8 + l == 13) ? etype[7:0] : 8'(w*8 + l);
   endfunction
   task send(input logic to_pcs);
      @(posedge xgmii_clk_in);
      #1;
      if (to_pcs) p_go = 1'b1;
      else m_go = 1'b1;
      @(posedge xgmii_clk_in);
      #1;
      m_go = 1'b0;
      p_go = 1'b0;
   endtask
   task tu_send(input int n, input logic [3:0] tail_keep);
      @(posedge clk_in);
      #1;
      for (int i = 0; i < n; i++) begin
         tu_tx_valid_in = 1'b1;
         tu_tx_data_in = 32'ha000_0000 + i;
         tu_tx_keep_in = (i == n - 1) ? tail_keep : 4'hf;
         tu_tx_last_in = (i == n - 1);
         @(posedge clk_in iff tu_tx_ready_out === 1'b1);
         #1;
      end
      tu_tx_valid_in = 1'b0;
      tu_tx_last_in = 1'b0;
      tu_tx_keep_in = 4'hf;
   endtask
   task t_rx_ptp;
      logic [63:0] w;
      n0 = lasts; e0 = rx_evs; tu_q.delete(); etype = 16'h88f7; words = 9'h004; lane4 = 1'b0;
      send(1'b1);
      for (int t = 0; t < 3000 && lasts == n0; t++) @(posedge clk_in);
      chk("tu_rx frames", n0 + 1, lasts);
      for (int i = 0; i < 8; i++) begin
         w = ew(i / 2);
         chk("tu_rx half", (i % 2) ? w[63:32] : w[31:0], tu_q[i]);
      end
      chk("tu_rx last keep", 4'hf, lk);
      chk("rx events", e0 + 1, rx_evs);
      chk("mac_rx frames", 0, m_ends);
      $display("t_rx_ptp done");
   endtask
   task t_rx_plain;
      for (int l4 = 0; l4 < 2; l4++) begin
         e0 = m_ends; n0 = lasts; u_mac.q.delete(); etype = 16'h0800; words = 9'h003; lane4 = l4[0];
         send(1'b1);
         for (int t = 0; t < 3000 && m_ends == e0; t++) @(posedge xgmii_clk_in);
         repeat (100) @(posedge clk_in);
         chk("mac_rx frames", e0 + 1, m_ends);
         for (int i = 0; i < 3; i++) chk("mac_rx word", ew(i), u_mac.q[i]);
         chk("tu_rx frames", n0, lasts);
      end
      $display("t_rx_plain done");
   endtask
   task t_tu_tx;
      e0 = p_ends; n0 = tx_evs; u_pcs.q.delete();
      tu_send(4, 4'hf);
      for (int t = 0; t < 3000 && p_ends == e0; t++) @(posedge xgmii_clk_in);
      repeat (10) @(posedge clk_in);
      chk("pcs_tx frames", e0 + 1, p_ends);
      chk("pcs_tx word0", 64'ha000_0001_a000_0000, u_pcs.q[0]);
      chk("pcs_tx word1", 64'ha000_0003_a000_0002, u_pcs.q[1]);
      chk("tx events", n0 + 1, tx_evs);
      $display("t_tu_tx done");
   endtask
   task t_ovf_both;
      e0 = p_ends; etype = 16'h0800; words = 9'h12c; lane4 = 1'b0;
      send(1'b0);
      repeat (400) @(posedge xgmii_clk_in);
      chk("oversize frame dropped", e0, p_ends);
      words = 9'h003;
      lane4 = 1'b1;
      fork
         send(1'b0);
         tu_send(3, 4'h3);
      join
      for (int t = 0; t < 3000 && p_ends < e0 + 2; t++) @(posedge xgmii_clk_in);
      chk("pcs_tx shared frames", e0 + 2, p_ends);
      $display("t_ovf_both done");
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #300000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_in);
      #1 rst_in = 1'b0;
      repeat (10) @(posedge clk_in);
      t_rx_ptp();
      t_rx_plain();
      t_tu_tx();
      t_ovf_both();
      chk("pcs_tx framing faults", 0, p_bad);
      chk("mac_rx framing faults", 0, m_bad);
      wrap_up();
   end
endmodule
